// ==== include/floppy_port_cfg.svh ====
/*
  timing counts and field constants for the floppy drive control port.
  assumes a 40 MHz system clock; counts are derived from printed times.
*/
`ifndef FLOPPY_PORT_CFG_SVH
`define FLOPPY_PORT_CFG_SVH
`define CLK_PERIOD_NS 25
`define CELL_TIME_NS 4000
`define CELL_CYCLES (`CELL_TIME_NS / `CLK_PERIOD_NS)
`define HALF_CELL_CYCLES (`CELL_CYCLES / 2)
`define STEP_PULSE_NS 200
`define STEP_PULSE_CYCLES ((`STEP_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STEP_PERIOD_MS 10
`define STEP_PERIOD_CYCLES (`STEP_PERIOD_MS * 1000000 / `CLK_PERIOD_NS)
`define INDEX_MIN_US 400
`define INDEX_MIN_CYCLES ((`INDEX_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOW_CUR_TRACK 7'h2b
`define ERASE_DELAY_CYCLES 8'h10
`define FIFO_DEPTH 16
`define TRACK_W 7
`endif

// ==== include/floppy_port_pkg.sv ====
/*
  types shared by the floppy drive control port.
  assumes the cfg header supplies the numeric constants.
*/
package floppy_port_pkg;
  typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE, OP_SEEK} op_t;
  typedef struct packed {
    logic reduced_write_current;
    logic drive_select;
    logic write_gate;
    logic erase_gate;
    logic head_load_request;
    logic head_step_pulse_n;
    logic step_direction_outward;
    logic drive_init_out_n;
  } drive_ctl_t;
endpackage

// ==== verilog/bit_fifo.sv ====
/*
  small synchronous fifo with valid/ready on both sides.
  assumes a single clock and a synchronous active-low reset.
*/
`timescale 1ns/100ps
module bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_r[rp_r];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==== verilog/floppy_port.sv ====
/*
  controller-side floppy drive control port: write encoder, read separator,
  head positioner and drive control lines.
  assumes drive pins are asynchronous to clk_sys and the sequencer issues
  one-cycle requests on the user side.
*/
// What this block does
// - reduced write current is asserted while the current track is above 43.
// - write bits are sent only as edges of the write stream, never as levels.
// - each 4 us cell begins with a clock edge and a one adds a mid-cell edge.
// - read bits come from whether a data edge falls between two clock edges.
// - the drive select output is high for drive 1 and low for drive 0.
// - write gate rises before the first bit of a field and falls after the last.
// - erase is enabled only after write gate rose, and drops later than it.
// - head load is asserted while a read or write operation runs.
// - a track move is two step pulses of at least 200 ns, steps at least 10 ms apart.
// - direction low steps inward and up, direction high steps outward and down.
// - index pulses are at least 400 us; they time operations and show speed.
// - the drive initialize output is asserted for the whole initialize.
// - head load is released whenever the port is idle.
`timescale 1ns/100ps
`include "floppy_port_cfg.svh"
module floppy_port #(
  parameter int STEP_PERIOD = `STEP_PERIOD_CYCLES,
  parameter int INDEX_MIN = `INDEX_MIN_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // sequencer control
  input wire logic init_req,
  input wire logic drive_sel_in,
  input wire logic read_start,
  input wire logic write_start,
  input wire logic op_stop,
  input wire logic seek_req,
  input wire logic seek_outward,
  output logic busy,
  // write data in
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic wr_bit,
  input wire logic wr_last,
  // read data out
  output logic rd_valid,
  output logic rd_bit,
  // status
  output logic [`TRACK_W-1:0] track,
  output logic index_seen,
  output logic up_to_speed,
  // drive pins
  input wire logic raw_data_n,
  input wire logic at_home_track,
  input wire logic index_in,
  output logic write_stream,
  output floppy_port_pkg::drive_ctl_t ctl
);
  localparam int CELL = `CELL_CYCLES;
  localparam int HALF = `HALF_CELL_CYCLES;

  logic [2:0] raw_s;
  logic [1:0] home_s;
  logic [2:0] idx_s;
  logic raw_edge, idx_rise, idx_fall;
  floppy_port_pkg::op_t op_r;
  logic [7:0] cell_r;
  logic ws_r, wg_r, er_r;
  logic [7:0] er_cnt_r;
  logic cell_end;
  logic cur_bit_r;
  logic cur_last_r;
  logic wr_have_r;
  logic wr_done_r;
  logic sel_r;
  logic [`TRACK_W-1:0] trk_r;
  logic step_r;
  logic dir_r;
  logic [1:0] pulses_r;
  logic [31:0] step_cnt_r;
  logic seek_busy_r;
  logic [31:0] idx_cnt_r;
  logic idx_seen_r, speed_r;
  logic [7:0] rd_cnt_r;
  logic rd_sync_r, rd_data_r, rdv_r, rdb_r;
  logic fifo_valid, fifo_bit, fifo_last, fifo_pop;

  function automatic logic edge_of(input logic a, input logic b);
    return a ^ b;
  endfunction

  // stage 0 of each chain feeds only stage 1
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      raw_s <= 3'h7; // pin idles high, so no false edge after reset
      home_s <= '0;
      idx_s <= '0;
    end else begin
      raw_s <= {raw_s[1:0], raw_data_n};
      home_s <= {home_s[0], at_home_track};
      idx_s <= {idx_s[1:0], index_in};
    end
  end
  assign raw_edge = edge_of(raw_s[2], raw_s[1]);
  assign idx_rise = idx_s[1] && !idx_s[2];
  assign idx_fall = !idx_s[1] && idx_s[2];

  // write bits are buffered so the sequencer can run ahead of the cell timer
  bit_fifo #(.WIDTH(2), .DEPTH(`FIFO_DEPTH)) u_wfifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data({wr_last, wr_bit}),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data({fifo_last, fifo_bit})
  );
  // a cell ends with the next bit already taken, so cells run back to back
  assign cell_end = wg_r && wr_have_r && (cell_r == 8'(CELL - 1));
  assign fifo_pop = (op_r == floppy_port_pkg::OP_WRITE) && !wr_done_r && (!wr_have_r || (cell_end && !cur_last_r));

  // operation state; init overrides everything
  always_ff @(posedge clk_sys) begin
    if (!rst_n || init_req) begin
      op_r <= floppy_port_pkg::OP_IDLE;
    end else begin
      case (op_r)
        floppy_port_pkg::OP_IDLE: begin
          if (write_start) begin
            op_r <= floppy_port_pkg::OP_WRITE;
          end else if (read_start) begin
            op_r <= floppy_port_pkg::OP_READ;
          end
        end
        floppy_port_pkg::OP_READ: begin
          if (op_stop) begin
            op_r <= floppy_port_pkg::OP_IDLE;
          end
        end
        floppy_port_pkg::OP_WRITE: begin
          if (wr_done_r && !er_r && !wg_r) begin
            op_r <= floppy_port_pkg::OP_IDLE;
          end
        end
        default: op_r <= floppy_port_pkg::OP_IDLE;
      endcase
    end
  end

  // cell timer; waits at zero while no bit is in hand (fifo underrun)
  always_ff @(posedge clk_sys) begin
    if (!rst_n || op_r != floppy_port_pkg::OP_WRITE || !wg_r || !wr_have_r) begin
      cell_r <= '0;
    end else if (cell_r == 8'(CELL - 1)) begin
      cell_r <= '0;
    end else begin
      cell_r <= cell_r + 8'h01;
    end
  end

  // write gate raised first, drops after the last cell of the field
  always_ff @(posedge clk_sys) begin
    if (!rst_n || init_req) begin
      wg_r <= 1'b0;
    end else if (op_r == floppy_port_pkg::OP_WRITE && !wr_done_r) begin
      wg_r <= 1'b1;
    end else if (wr_done_r) begin
      wg_r <= 1'b0;
    end
  end

  // erase follows write gate by a fixed delay and falls only after it
  always_ff @(posedge clk_sys) begin
    if (!rst_n || init_req) begin
      er_r <= 1'b0;
      er_cnt_r <= '0;
    end else if (wg_r && !er_r && !wr_done_r) begin
      er_cnt_r <= er_cnt_r + 8'h01;
      if (er_cnt_r == `ERASE_DELAY_CYCLES) begin
        er_r <= 1'b1;
      end
    end else if (!wg_r) begin
      er_r <= 1'b0;
      er_cnt_r <= '0;
    end
  end

  // bit fetch: one fifo entry per cell
  always_ff @(posedge clk_sys) begin
    if (!rst_n || op_r != floppy_port_pkg::OP_WRITE) begin
      wr_have_r <= 1'b0;
      wr_done_r <= 1'b0;
      cur_bit_r <= 1'b0;
      cur_last_r <= 1'b0;
    end else if (cell_end) begin
      wr_have_r <= fifo_pop && fifo_valid;
      wr_done_r <= cur_last_r;
      cur_bit_r <= fifo_bit;
      cur_last_r <= fifo_last;
    end else if (fifo_pop && fifo_valid) begin
      wr_have_r <= 1'b1;
      cur_bit_r <= fifo_bit;
      cur_last_r <= fifo_last;
    end
  end

  // encoder toggles: clock edge at cell start, data edge mid-cell for a one
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ws_r <= 1'b0;
    end else if (wg_r && wr_have_r) begin
      if (cell_r == 8'h00) begin
        ws_r <= !ws_r;
      end else if (cell_r == 8'(HALF) && cur_bit_r) begin
        ws_r <= !ws_r;
      end
    end
  end
  assign write_stream = ws_r;

  // read separator: after a clock edge, look for a data edge before the next
  always_ff @(posedge clk_sys) begin
    if (!rst_n || op_r != floppy_port_pkg::OP_READ) begin
      rd_cnt_r <= '0;
      rd_sync_r <= 1'b0;
      rd_data_r <= 1'b0;
      rdv_r <= 1'b0;
      rdb_r <= 1'b0;
    end else begin
      rdv_r <= 1'b0;
      if (rd_cnt_r != 8'hff) begin
        rd_cnt_r <= rd_cnt_r + 8'h01;
      end
      if (raw_edge) begin
        if (rd_sync_r && rd_cnt_r < 8'(HALF + HALF / 2)) begin
          rd_data_r <= 1'b1;
        end else begin
          if (rd_sync_r) begin
            rdv_r <= 1'b1;
            rdb_r <= rd_data_r;
          end
          rd_sync_r <= 1'b1;
          rd_data_r <= 1'b0;
          rd_cnt_r <= '0;
        end
      end
    end
  end
  assign rd_valid = rdv_r;
  assign rd_bit = rdb_r;

  // drive select latched when idle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sel_r <= 1'b0;
    end else if (op_r == floppy_port_pkg::OP_IDLE && !seek_busy_r) begin
      sel_r <= drive_sel_in;
    end
  end

  // stepper: two pulses per track, step period paced by a counter
  always_ff @(posedge clk_sys) begin
    if (!rst_n || init_req) begin
      seek_busy_r <= 1'b0;
      step_r <= 1'b0;
      dir_r <= 1'b0;
      pulses_r <= '0;
      step_cnt_r <= '0;
    end else if (!seek_busy_r) begin
      if (seek_req && op_r == floppy_port_pkg::OP_IDLE && step_cnt_r == '0) begin
        seek_busy_r <= 1'b1;
        dir_r <= seek_outward;
        pulses_r <= 2'h2;
        step_cnt_r <= '0;
      end else if (step_cnt_r != '0) begin
        step_cnt_r <= step_cnt_r - 32'h1;
      end
    end else begin
      step_cnt_r <= step_cnt_r + 32'h1;
      if (step_cnt_r < 32'(`STEP_PULSE_CYCLES)) begin
        step_r <= 1'b1;
      end else if (step_cnt_r < 32'(2 * `STEP_PULSE_CYCLES)) begin
        step_r <= 1'b0;
      end else begin
        step_cnt_r <= '0;
        if (pulses_r == 2'h1) begin
          seek_busy_r <= 1'b0;
          step_cnt_r <= 32'(STEP_PERIOD);
        end
        pulses_r <= pulses_r - 2'h1;
      end
    end
  end

  // track counter; home indication wins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      trk_r <= '0;
    end else if (home_s[1]) begin
      trk_r <= '0;
    end else if (seek_busy_r && pulses_r == 2'h1 && step_cnt_r >= 32'(2 * `STEP_PULSE_CYCLES)) begin
      if (dir_r) begin
        trk_r <= trk_r - 7'h01;
      end else begin
        trk_r <= trk_r + 7'h01;
      end
    end
  end
  assign track = trk_r;

  // index: a pulse counts only if it lasts the minimum; the first good one means speed
  always_ff @(posedge clk_sys) begin
    if (!rst_n || init_req) begin
      idx_cnt_r <= '0;
      idx_seen_r <= 1'b0;
      speed_r <= 1'b0;
    end else begin
      idx_seen_r <= 1'b0;
      if (idx_rise) begin
        idx_cnt_r <= '0;
      end else if (idx_s[1] && idx_cnt_r != 32'hffffffff) begin
        idx_cnt_r <= idx_cnt_r + 32'h1;
      end
      if (idx_fall && idx_cnt_r >= 32'(INDEX_MIN - 1)) begin
        idx_seen_r <= 1'b1;
        speed_r <= 1'b1;
      end
    end
  end
  assign index_seen = idx_seen_r;
  assign up_to_speed = speed_r;

  assign busy = (op_r != floppy_port_pkg::OP_IDLE) || seek_busy_r;
  assign ctl.reduced_write_current = (trk_r > `LOW_CUR_TRACK);
  assign ctl.drive_select = sel_r;
  assign ctl.write_gate = wg_r;
  assign ctl.erase_gate = er_r;
  assign ctl.head_load_request = (op_r != floppy_port_pkg::OP_IDLE);
  assign ctl.head_step_pulse_n = !step_r;
  assign ctl.step_direction_outward = dir_r;
  assign ctl.drive_init_out_n = !(init_req || !rst_n);

  AST_LOWCUR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctl.reduced_write_current == (trk_r > 7'h2b)) else $error("low current mismatch");
  AST_QUIET: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !wg_r && !$past(wg_r) |=> $stable(ws_r)) else $error("write stream moved without gate");
  AST_CELL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wg_r && wr_have_r && cell_r == 8'h00 |=> ws_r != $past(ws_r)) else $error("no clock edge");
  AST_ERASE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    er_r |-> wg_r || $past(wg_r)) else $error("erase without write gate");
  AST_HEAD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op_r == floppy_port_pkg::OP_IDLE |-> !ctl.head_load_request) else $error("head loaded idle");
  AST_STEPW: assert property (@(posedge clk_sys) disable iff (!rst_n || init_req)
    $rose(step_r) |-> step_r [*8]) else $error("step pulse too short");
  AST_INIT: assert property (@(posedge clk_sys)
    init_req |-> !ctl.drive_init_out_n) else $error("init not forwarded");
  AST_HOME: assert property (@(posedge clk_sys) disable iff (!rst_n)
    home_s[1] |=> trk_r == 7'h00) else $error("track not cleared at home");
  AST_SEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    busy |=> $stable(sel_r)) else $error("select changed while busy");
  COV_WRITE: cover property (@(posedge clk_sys) disable iff (!rst_n) $fell(wg_r));
  COV_READ: cover property (@(posedge clk_sys) disable iff (!rst_n) rdv_r && rdb_r);
  COV_STEP: cover property (@(posedge clk_sys) disable iff (!rst_n) $fell(seek_busy_r));
  COV_SPEED: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(speed_r));
endmodule

// ==== tb/floppy_drive_model.sv ====
/*
  behavioural drive: head position, home, index and raw read stream.
  assumes the port's step and direction lines; cells are paced by its own 200 ns tick.
*/
`timescale 1ns/100ps
module floppy_drive_model (
  // head positioner
  input wire logic head_step_pulse_n,
  input wire logic step_direction_outward,
  // drive status
  output logic at_home_track,
  output logic index_in,
  output logic raw_data_n
);
  logic link_clk;
  int pos;
  int half;
  initial begin
    link_clk = 1'b0;
    #37;
    forever #100 link_clk = ~link_clk;
  end
  initial begin
    pos = 0;
    half = 0;
    index_in = 1'b0;
    raw_data_n = 1'b1;
  end
  assign at_home_track = (pos == 0);
  // two pulses make one track; the head stops at the outer stop
  always @(negedge head_step_pulse_n) begin
    half++;
    if (half == 2) begin
      half = 0;
      pos = step_direction_outward ? ((pos > 0) ? pos - 1 : 0) : pos + 1;
    end
  end
  // each cell opens with a clock edge; a one adds an edge at mid cell
  task automatic send_cells(input logic [7:0] bits);
    int i;
    for (i = 7; i >= -1; i--) begin
      @(posedge link_clk);
      raw_data_n = ~raw_data_n;
      if (i >= 0) begin
        repeat (10) @(posedge link_clk);
        if (bits[i]) raw_data_n = ~raw_data_n;
        repeat (9) @(posedge link_clk);
      end
    end
  endtask
  task automatic pulse_index(input int ns);
    index_in = 1'b1;
    #(ns);
    index_in = 1'b0;
  endtask
endmodule

// ==== tb/floppy_port_test.sv ====
/*
  self-checking bench for the floppy drive control port.
  assumes floppy_drive_model on the drive pins and shortened step and index counts.
*/
`timescale 1ns/100ps
`include "floppy_port_cfg.svh"
module floppy_port_test;
  logic clk_sys, rst_n, init_req, drive_sel_in, read_start, write_start, op_stop;
  logic seek_req, seek_outward, busy, wr_valid, wr_ready, wr_bit, wr_last, rd_valid, rd_bit;
  logic [`TRACK_W-1:0] track;
  logic index_seen, up_to_speed, raw_data_n, at_home_track, index_in, write_stream;
  floppy_port_pkg::drive_ctl_t ctl;
  int errors, compares;
  floppy_port #(.STEP_PERIOD(50), .INDEX_MIN(20)) u_floppy_port (
    .clk_sys(clk_sys), .rst_n(rst_n), .init_req(init_req), .drive_sel_in(drive_sel_in),
    .read_start(read_start), .write_start(write_start), .op_stop(op_stop), .seek_req(seek_req),
    .seek_outward(seek_outward), .busy(busy), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_bit(wr_bit), .wr_last(wr_last), .rd_valid(rd_valid), .rd_bit(rd_bit), .track(track),
    .index_seen(index_seen), .up_to_speed(up_to_speed), .raw_data_n(raw_data_n),
    .at_home_track(at_home_track), .index_in(index_in), .write_stream(write_stream), .ctl(ctl));
  floppy_drive_model u_floppy_drive_model (
    .head_step_pulse_n(ctl.head_step_pulse_n), .step_direction_outward(ctl.step_direction_outward),
    .at_home_track(at_home_track), .index_in(index_in), .raw_data_n(raw_data_n));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic close_out();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic t_index(input int ns, input logic exp);
    int n, seen;
    seen = 0;
    fork
      u_floppy_drive_model.pulse_index(ns);
      for (n = 0; n < 120; n++) begin
        tick();
        if (index_seen === 1'b1) seen++;
      end
    join
    chk(seen == int'(exp), "index pulse count");
    chk(up_to_speed === exp, "speed flag");
  endtask
  task automatic t_init();
    @(posedge clk_sys);
    init_req <= 1'b1;
    repeat (5) begin
      tick();
      chk(ctl.drive_init_out_n === 1'b0, "init not forwarded");
    end
    @(posedge clk_sys);
    init_req <= 1'b0;
    tick();
    chk(ctl.drive_init_out_n === 1'b1, "init held after release");
    chk(up_to_speed === 1'b0, "speed flag kept over init");
  endtask
  task automatic step_once(input logic outward);
    int lows, w, n;
    lows = 0;
    w = 0;
    n = 0;
    @(posedge clk_sys);
    seek_req <= 1'b1;
    seek_outward <= outward;
    @(posedge clk_sys);
    seek_req <= 1'b0;
    #1;
    while (busy !== 1'b1 && n < 3) begin
      tick();
      n++;
    end
    while (busy === 1'b1 && n < 200) begin
      if (ctl.head_step_pulse_n === 1'b0) begin
        w++;
        chk(ctl.step_direction_outward === outward, "step direction");
      end else if (w != 0) begin
        lows++;
        chk(w >= `STEP_PULSE_CYCLES, "step pulse too short");
        w = 0;
      end
      tick();
      n++;
    end
    chk(lows == 2, "two pulses per track");
  endtask
  task automatic t_seek(input logic outward);
    logic [`TRACK_W-1:0] exp;
    int k;
    exp = outward ? 7'h2c : 7'h00;
    chk(track === exp, "start track");
    for (k = 0; k < 44; k++) begin
      step_once(outward);
      exp = outward ? exp - 7'h01 : exp + 7'h01;
      chk(track === exp, "track after step");
      if (k == 0) begin
        @(posedge clk_sys);
        seek_req <= 1'b1;
        @(posedge clk_sys);
        seek_req <= 1'b0;
        #1;
        tick();
        chk(busy === 1'b0 && track === exp, "seek inside step spacing taken");
      end
      chk(ctl.reduced_write_current === (exp > `LOW_CUR_TRACK), "reduced current");
      repeat (55) @(posedge clk_sys);
    end
  endtask
  task automatic t_write();
    logic [15:0] pat, got;
    int e[$];
    int n, i, nb, c;
    logic prev, er;
    pat = 16'hb4e1;
    got = 16'h0000;
    er = 1'b0;
    @(posedge clk_sys);
    drive_sel_in <= 1'b1;
    for (i = 0; i < 16; i++) begin
      wr_valid <= 1'b1;
      wr_bit <= pat[15-i];
      wr_last <= (i == 15);
      @(posedge clk_sys);
    end
    #1;
    chk(wr_ready === 1'b0, "full fifo still ready");
    prev = write_stream;
    @(posedge clk_sys);
    wr_valid <= 1'b0;
    wr_last <= 1'b0;
    repeat (20) @(posedge clk_sys);
    chk(write_stream === prev, "stream moved with gate low");
    write_start <= 1'b1;
    @(posedge clk_sys);
    write_start <= 1'b0;
    #1;
    n = 0;
    while (ctl.write_gate !== 1'b1 && n < 3) begin
      tick();
      n++;
    end
    chk(ctl.write_gate === 1'b1 && ctl.erase_gate === 1'b0, "gate order at start");
    chk(ctl.head_load_request === 1'b1 && ctl.drive_select === 1'b1, "load or select");
    n = 0;
    while (ctl.write_gate === 1'b1 && n < 4000) begin
      if (write_stream !== prev) e.push_back(n);
      if (ctl.erase_gate === 1'b1) er = 1'b1;
      prev = write_stream;
      tick();
      n++;
    end
    chk(er === 1'b1 && ctl.erase_gate === 1'b1, "erase missing or dropped early");
    repeat (3) tick();
    chk(ctl.erase_gate === 1'b0 && ctl.head_load_request === 1'b0, "erase or head held");
    chk(write_stream === prev, "stream moved after gate");
    i = 0;
    nb = 0;
    c = 0;
    while (i < e.size() && nb < 16) begin
      if (nb > 0) chk(e[i] - c == `CELL_CYCLES, "cell spacing");
      c = e[i];
      if (i + 1 < e.size() && e[i+1] - e[i] < 120) begin
        chk(e[i+1] - e[i] == `HALF_CELL_CYCLES, "data edge place");
        got[15-nb] = 1'b1;
        i += 2;
      end else i += 1;
      nb++;
    end
    chk(nb == 16 && got === pat, "written bits");
  endtask
  task automatic t_read();
    logic [7:0] pat, got;
    int cnt, n;
    pat = 8'h9c;
    got = 8'h00;
    cnt = 0;
    @(posedge clk_sys);
    drive_sel_in <= 1'b0;
    read_start <= 1'b1;
    @(posedge clk_sys);
    read_start <= 1'b0;
    #1;
    tick();
    chk(ctl.head_load_request === 1'b1 && ctl.drive_select === 1'b0, "read load or select");
    fork
      u_floppy_drive_model.send_cells(pat);
      for (n = 0; n < 1600; n++) begin
        tick();
        if (rd_valid === 1'b1) begin
          got = {got[6:0], rd_bit};
          cnt++;
        end
      end
    join
    chk(cnt == 8 && got === pat, "read bits");
    @(posedge clk_sys);
    op_stop <= 1'b1;
    @(posedge clk_sys);
    op_stop <= 1'b0;
    #1;
    repeat (3) tick();
    chk(ctl.head_load_request === 1'b0 && busy === 1'b0, "head left loaded");
  endtask
  initial begin
    errors = 0;
    compares = 0;
    {rst_n, init_req, drive_sel_in, read_start, write_start, op_stop} = 6'h00;
    {seek_req, seek_outward, wr_valid, wr_bit, wr_last} = 5'h00;
    tick();
    chk(ctl.drive_init_out_n === 1'b0, "init not forwarded in reset");
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    tick();
    chk(ctl.head_load_request === 1'b0 && ctl.write_gate === 1'b0, "idle outputs");
    t_index(250, 1'b0);
    t_index(1000, 1'b1);
    t_init();
    t_seek(1'b0);
    t_write();
    t_read();
    t_seek(1'b1);
    chk(at_home_track === 1'b1 && track === 7'h00, "not home");
    close_out();
  end
  // the whole run takes well under a millisecond
  initial begin
    #2000000;
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    close_out();
  end
endmodule
